// >>> hw/usc_top.sv
// Serial transceiver: APB registers, clocking, transmit and receive
`timescale 1ns/1ps
`include "usc_consts.svh"
module usc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire usc_pkg::usc_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe
);
  // Whole state of the unit
  typedef struct packed {
    logic [2:0] rxs; // Receive pin stages
    logic [2:0] xks; // Clock pin stages
    logic rxf; // Filtered receive level
    logic xkf; // Filtered clock level
    logic [12:0] ctrl; // Control register
    logic [11:0] baud; // Divisor
    logic [8:0] txbuf; // Transmit buffer
    logic txfull; // Buffer holds a character
    logic tx_complete_flag; // Transmit complete
    usc_pkg::usc_tx_st_t txst;
    logic [8:0] txsh; // Transmit shifter
    logic [3:0] txn; // Bits sent
    logic txpar; // Running parity
    logic [3:0] txpre; // Bit prescaler
    logic txd; // Line driver
    logic transfer_clock_pin; // Master clock level
    usc_pkg::usc_rx_st_t rxst;
    logic [3:0] rxcnt; // Sample phase
    logic [8:0] rxsh; // Receive shifter
    logic [3:0] rxn; // Bits taken
    logic rxpar; // Running parity
    logic rxpe; // Parity mismatch
    logic pend; // Third level occupied
    usc_pkg::usc_rx_ent_t held; // Third level content
    logic ovr; // Overrun for next entry
    logic [31:0] rdat; // Read data
  } usc_top_st_t;

  logic [1:0] rsync_q; // Reset release stages
  logic rst_n; // Synchronised reset
  usc_top_st_t s, n;
  logic tick;
  logic sync_m, master, slave, u2x, pol, pen, odd, stop2;
  logic [3:0] nbits, osr_m1, mid;
  logic xk_chg, rise, fall, chg_e, smp_e;
  logic tx_bit, rx_samp, rx_done;
  logic acc, setup, rd_pop, hit, blo_wr;
  logic push, pop, f_empty, f_full;
  logic [8:0] rx_align;
  usc_pkg::usc_rx_ent_t fr_ent, push_ent, head;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rsync_q <= 2'h0;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  // Data bits for the size field; codes four to six fall back to eight
  function automatic logic [3:0] size_bits(input logic [2:0] sz);
    case (sz)
      3'h0: size_bits = 4'h5;
      3'h1: size_bits = 4'h6;
      3'h2: size_bits = 4'h7;
      3'h3: size_bits = 4'h8;
      3'h7: size_bits = 4'h9;
      default: size_bits = 4'h8;
    endcase
  endfunction

  // Mode decode; speed bit is ignored when synchronous
  assign sync_m = s.ctrl[`USC_C_SYNC];
  assign master = sync_m && s.ctrl[`USC_C_DIR];
  assign slave = sync_m && !s.ctrl[`USC_C_DIR];
  assign u2x = s.ctrl[`USC_C_U2X] && !sync_m;
  assign pol = s.ctrl[`USC_C_POL];
  assign pen = s.ctrl[`USC_C_PEN];
  assign odd = s.ctrl[`USC_C_PODD];
  assign stop2 = s.ctrl[`USC_C_STOP2];
  // One format for both directions
  assign nbits = size_bits(s.ctrl[`USC_C_SZ+:3]);
  assign osr_m1 = u2x ? `USC_OSR2X_M1 : `USC_OSRN_M1;
  assign mid = {1'b0, osr_m1[3:1]};

  // Clock pin driven only as synchronous master
  assign xck_oe = master;
  assign xck_o = s.transfer_clock_pin && master;
  assign txd_o = s.txd;

  // Slave edge: stages two and three agree on a new level
  assign xk_chg = (s.xks[1] == s.xks[2]) && (s.xks[2] != s.xkf);
  assign rise = master ? (tick && !s.transfer_clock_pin)
                       : (slave && xk_chg && s.xks[2]);
  assign fall = master ? (tick && s.transfer_clock_pin)
                       : (slave && xk_chg && !s.xks[2]);
  // Polarity picks change and sample edges
  assign chg_e = pol ? fall : rise;
  assign smp_e = pol ? rise : fall;

  // Bit strobes per mode
  assign tx_bit = sync_m ? chg_e : (tick && s.txpre == 4'h0);
  assign rx_samp = sync_m ? smp_e : (tick && s.rxcnt == mid);

  // Received character aligned to bit zero
  assign rx_align = s.rxsh >> (4'h9 - nbits);
  assign rx_done = (s.rxst == usc_pkg::USC_RX_STOP) && rx_samp;
  assign fr_ent.pe = s.rxpe;
  assign fr_ent.overrun_flag = s.ovr;
  assign fr_ent.fe = !s.rxf;
  assign fr_ent.data = rx_align;
  // Held character drains first whenever room appears
  assign push = (rx_done || s.pend) && !f_full;
  assign push_ent = s.pend ? s.held : fr_ent;

  // Bus phases
  assign acc = apb.psel && apb.penable;
  assign setup = apb.psel && !apb.penable;
  assign hit = (apb.paddr == `USC_OFS_DATA) ||
               (apb.paddr == `USC_OFS_STAT) ||
               (apb.paddr == `USC_OFS_CTRL) ||
               (apb.paddr == `USC_OFS_BLO) ||
               (apb.paddr == `USC_OFS_BHI);
  // Read data is latched in setup, so access always completes
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = s.rdat;
  // Each data read advances the FIFO exactly once
  assign rd_pop = acc && !apb.pwrite &&
                  apb.paddr == `USC_OFS_DATA;
  assign pop = rd_pop;
  assign blo_wr = acc && apb.pwrite && apb.paddr == `USC_OFS_BLO;

  usc_baud u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .div(n.baud),
    .reload(blo_wr),
    .tick(tick)
  );

  usc_rxfifo u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(push),
    .din(push_ent),
    .pop(pop),
    .head(head),
    .empty(f_empty),
    .full(f_full)
  );

  // Next-state logic of the whole unit
  always_comb
  begin
    n = s;
    // Pin synchronisers, three stages each
    n.rxs = {s.rxs[1:0], rxd_i};
    n.xks = {s.xks[1:0], xck_i};
    if (s.rxs[1] == s.rxs[2])
      n.rxf = s.rxs[2];
    if (s.xks[1] == s.xks[2])
      n.xkf = s.xks[2];
    // Master clock toggles per tick: divide by two
    if (master && tick)
      n.transfer_clock_pin = !s.transfer_clock_pin;
    else if (!master)
      n.transfer_clock_pin = 1'b0;

    // Read data captured in the setup cycle
    if (setup)
    begin
      n.rdat = 32'h0000_0000;
      case (apb.paddr)
        `USC_OFS_DATA: n.rdat[8:0] = head.data;
        `USC_OFS_STAT:
        begin
          n.rdat[`USC_S_RXC] = !f_empty;
          n.rdat[`USC_S_TXE] = !s.txfull;
          n.rdat[`USC_S_TXC] = s.tx_complete_flag;
          n.rdat[`USC_S_FE] = head.fe;
          n.rdat[`USC_S_DOR] = head.overrun_flag;
          n.rdat[`USC_S_RX8] = head.data[8];
          n.rdat[`USC_S_PE] = head.pe;
        end
        `USC_OFS_CTRL: n.rdat[12:0] = s.ctrl;
        `USC_OFS_BLO: n.rdat[7:0] = s.baud[7:0];
        `USC_OFS_BHI: n.rdat[3:0] = s.baud[11:8];
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (acc && apb.pwrite)
    begin
      case (apb.paddr)
        `USC_OFS_DATA:
        begin
          // Ninth bit comes from the control register
          n.txbuf = {s.ctrl[`USC_C_TX8], apb.pwdata[7:0]};
          n.txfull = 1'b1;
        end
        `USC_OFS_STAT:
          if (apb.pwdata[`USC_S_TXC])
            n.tx_complete_flag = 1'b0;
        `USC_OFS_CTRL: n.ctrl = apb.pwdata[12:0];
        `USC_OFS_BLO: n.baud[7:0] = apb.pwdata[7:0];
        `USC_OFS_BHI: n.baud[11:8] = apb.pwdata[3:0];
        default: n.ctrl = s.ctrl;
      endcase
    end

    // Transmit prescaler counts ticks per bit
    if (tick)
      n.txpre = (s.txpre == 4'h0) ? osr_m1 : s.txpre - 4'h1;

    // Transmitter
    if (tx_bit)
    begin
      case (s.txst)
        usc_pkg::USC_TX_IDLE:
        begin
          n.txd = 1'b1;
          if (s.txfull && s.ctrl[`USC_C_TXEN])
          begin
            n.txsh = s.txbuf;
            n.txfull = 1'b0;
            n.txd = 1'b0;
            n.txst = usc_pkg::USC_TX_START;
          end
        end
        usc_pkg::USC_TX_START:
        begin
          // Least significant bit first
          n.txd = s.txsh[0];
          n.txpar = s.txsh[0];
          n.txsh = {1'b0, s.txsh[8:1]};
          n.txn = 4'h1;
          n.txst = usc_pkg::USC_TX_DATA;
        end
        usc_pkg::USC_TX_DATA:
          if (s.txn == nbits)
          begin
            n.txn = 4'h0;
            if (pen)
            begin
              n.txd = s.txpar ^ odd;
              n.txst = usc_pkg::USC_TX_PAR;
            end
            else
            begin
              n.txd = 1'b1;
              n.txst = usc_pkg::USC_TX_STOP;
            end
          end
          else
          begin
            n.txd = s.txsh[0];
            n.txpar = s.txpar ^ s.txsh[0];
            n.txsh = {1'b0, s.txsh[8:1]};
            n.txn = s.txn + 4'h1;
          end
        usc_pkg::USC_TX_PAR:
        begin
          n.txd = 1'b1;
          n.txst = usc_pkg::USC_TX_STOP;
        end
        usc_pkg::USC_TX_STOP:
          if (stop2 && s.txn == 4'h0)
            n.txn = 4'h1;
          else if (s.txfull && s.ctrl[`USC_C_TXEN])
          begin
            // Next start bit follows at once
            n.txsh = s.txbuf;
            n.txfull = 1'b0;
            n.txd = 1'b0;
            n.txst = usc_pkg::USC_TX_START;
          end
          else
          begin
            n.txd = 1'b1;
            n.tx_complete_flag = 1'b1;
            n.txst = usc_pkg::USC_TX_IDLE;
          end
        default:
        begin
          n.txd = 1'b1;
          n.txst = usc_pkg::USC_TX_IDLE;
        end
      endcase
    end

    // Receive sample phase wraps at the oversampling count
    if (tick && !sync_m)
      n.rxcnt = (s.rxcnt == osr_m1) ? 4'h0 : s.rxcnt + 4'h1;

    // Third level drains or is lost at the next start
    if (s.pend && !f_full)
      n.pend = 1'b0;

    // Receiver
    case (s.rxst)
      usc_pkg::USC_RX_IDLE:
        if (s.ctrl[`USC_C_RXEN] && !s.rxf &&
            (sync_m ? smp_e : tick))
        begin
          if (s.pend && f_full)
          begin
            n.pend = 1'b0;
            n.ovr = 1'b1;
          end
          n.rxcnt = 4'h0;
          n.rxn = 4'h0;
          n.rxpar = 1'b0;
          n.rxpe = 1'b0;
          // Synchronous start is already sampled
          n.rxst = sync_m ? usc_pkg::USC_RX_DATA
                          : usc_pkg::USC_RX_START;
        end
      usc_pkg::USC_RX_START:
        if (rx_samp)
          // A high level here was a glitch, not a start
          n.rxst = s.rxf ? usc_pkg::USC_RX_IDLE
                         : usc_pkg::USC_RX_DATA;
      usc_pkg::USC_RX_DATA:
        if (rx_samp)
        begin
          n.rxsh = {s.rxf, s.rxsh[8:1]};
          n.rxpar = s.rxpar ^ s.rxf;
          n.rxn = s.rxn + 4'h1;
          if (s.rxn + 4'h1 == nbits)
            n.rxst = pen ? usc_pkg::USC_RX_PAR
                         : usc_pkg::USC_RX_STOP;
        end
      usc_pkg::USC_RX_PAR:
        if (rx_samp)
        begin
          n.rxpe = s.rxf != (s.rxpar ^ odd);
          n.rxst = usc_pkg::USC_RX_STOP;
        end
      usc_pkg::USC_RX_STOP:
        if (rx_samp)
        begin
          // Only the first stop is checked; a second is idle
          // Overrun travels with this character only, held or pushed
          if (f_full)
          begin
            n.pend = 1'b1;
            n.held = fr_ent;
          end
          n.ovr = 1'b0;
          n.rxst = usc_pkg::USC_RX_IDLE;
        end
      default: n.rxst = usc_pkg::USC_RX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ctrl <= `USC_CTRL_RST;
      s.baud <= `USC_BAUD_RST;
      s.txst <= usc_pkg::USC_TX_IDLE;
      s.rxst <= usc_pkg::USC_RX_IDLE;
      s.txd <= 1'b1;
      s.rxs <= 3'h7;
      s.rxf <= 1'b1;
    end
    else
      s <= n;
  end

  property p_xck_div;
    @(posedge mclk) disable iff (!rst_n)
      (master && tick) |=> (s.transfer_clock_pin != $past(s.transfer_clock_pin));
  endproperty
  a_xck_div: assert property (p_xck_div)
    else $error("master clock did not toggle on tick");

  property p_idle_high;
    @(posedge mclk) disable iff (!rst_n)
      (s.txst == usc_pkg::USC_TX_IDLE) |-> txd_o;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle line not high");

  sequence s_tx_load;
    (s.txst == usc_pkg::USC_TX_IDLE) ##1
      (s.txst == usc_pkg::USC_TX_START);
  endsequence
  property p_start_low;
    @(posedge mclk) disable iff (!rst_n)
      s_tx_load |-> !txd_o && !s.txfull;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low after load");

  sequence s_tx_end;
    (s.txst == usc_pkg::USC_TX_STOP) ##1
      (s.txst == usc_pkg::USC_TX_IDLE);
  endsequence
  property p_txc;
    @(posedge mclk) disable iff (!rst_n)
      s_tx_end |-> s.tx_complete_flag;
  endproperty
  a_txc: assert property (p_txc)
    else $error("complete flag not set after frame");

  property p_fe;
    @(posedge mclk) disable iff (!rst_n)
      (rx_done && !s.rxf && f_empty && !s.pend) |=> head.fe;
  endproperty
  a_fe: assert property (p_fe)
    else $error("frame error not stored");

  property p_third;
    @(posedge mclk) disable iff (!rst_n)
      (rx_done && s.rxf && f_full && !pop) |=>
        s.pend ##1 (s.pend || !f_full);
  endproperty
  a_third: assert property (p_third)
    else $error("character not held in shifter");
endmodule

// >>> inc/usc_consts.svh
// Offsets, field positions, reset values and counts of the serial unit
// Overview of operation
// - Two-entry circular receive FIFO, read pops once
// - Error flags and ninth bit stored per character
// - Shift register holds third character until start
// - Four clock modes from sync, speed, direction
// - Clock pin used only in synchronous mode
// - Divisor down-counter reloads at zero or low write
// - Transmit bit clock divides ticks 16, 8, 2
// - Receiver steps 16, 8 or 2 states
// - Divisor is twelve bits from two bytes
// - Double speed acts only in asynchronous mode
// - Double speed receiver uses eight samples
// - Slave clock synchronised then edge detected
// - Change and sample on opposite clock edges
// - Start, five to nine data, parity, stops
// - Start, data LSB first, parity, stops
// - Idle line is driven high
// - One shared frame format for both directions
// - Only first stop bit checked for errors
// - Parity is XOR of data, inverted odd
// - Complete flag set when frame out, buffer empty
// - Size value seven selects nine-bit characters
// - Upper parity bit enables parity insertion
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
// Register byte offsets
`define USC_OFS_DATA 12'h000
`define USC_OFS_STAT 12'h004
`define USC_OFS_CTRL 12'h008
`define USC_OFS_BLO 12'h00C
`define USC_OFS_BHI 12'h010
// Control field positions
`define USC_C_RXEN 0
`define USC_C_TXEN 1
`define USC_C_U2X 2
`define USC_C_TX8 3
`define USC_C_SYNC 4
`define USC_C_DIR 5
`define USC_C_POL 6
`define USC_C_STOP2 7
`define USC_C_PODD 8
`define USC_C_PEN 9
`define USC_C_SZ 10
// Status field positions
`define USC_S_RXC 0
`define USC_S_TXE 1
`define USC_S_TXC 2
`define USC_S_FE 3
`define USC_S_DOR 4
`define USC_S_RX8 5
`define USC_S_PE 6
// Reset values
`define USC_CTRL_RST 13'h0C00
`define USC_BAUD_RST 12'h000
// Oversampling counts less one
`define USC_OSRN_M1 4'hF
`define USC_OSR2X_M1 4'h7
`endif

// >>> inc/usc_pkg.sv
// Types shared by the serial unit modules
package usc_pkg;
  typedef enum logic [4:0] {
    USC_TX_IDLE = 5'h01, USC_TX_START = 5'h02, USC_TX_DATA = 5'h04,
    USC_TX_PAR = 5'h08, USC_TX_STOP = 5'h10
  } usc_tx_st_t;
  typedef enum logic [4:0] {
    USC_RX_IDLE = 5'h01, USC_RX_START = 5'h02, USC_RX_DATA = 5'h04,
    USC_RX_PAR = 5'h08, USC_RX_STOP = 5'h10
  } usc_rx_st_t;
  typedef struct packed {
    logic pe;
    logic overrun_flag;
    logic fe;
    logic [8:0] data;
  } usc_rx_ent_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usc_apb_req_t;
  typedef struct packed {
    logic [11:0] cnt;
  } usc_baud_st_t;
  typedef struct packed {
    usc_rx_ent_t [1:0] ent;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } usc_fifo_st_t;
endpackage

// >>> hw/usc_baud.sv
// Baud rate down-counter producing generator ticks
`timescale 1ns/1ps
module usc_baud #(
  parameter int W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] div,
  input wire logic reload,
  output logic tick
);
  usc_pkg::usc_baud_st_t s, n; // Counter state

  // One tick per zero: rate is clock over divisor plus one
  assign tick = (s.cnt == '0);

  // Reload at zero or on a low-byte write
  always_comb
  begin
    n = s;
    if (reload || tick)
      n.cnt = div;
    else
      n.cnt = s.cnt - 12'h001;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  property p_reload;
    @(posedge mclk) disable iff (!rst_n)
      (tick && !reload) |=> (s.cnt == $past(div));
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter did not reload after tick");

  property p_count;
    @(posedge mclk) disable iff (!rst_n)
      (!tick && !reload) |=> (s.cnt == $past(s.cnt) - 12'h001);
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not step down");
endmodule

// >>> hw/usc_rxfifo.sv
// Two-entry receive FIFO holding data with its status
`timescale 1ns/1ps
module usc_rxfifo (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic push,
  input wire usc_pkg::usc_rx_ent_t din,
  input wire logic pop,
  output usc_pkg::usc_rx_ent_t head,
  output logic empty,
  output logic full
);
  usc_pkg::usc_fifo_st_t s, n; // Entries and pointers

  // Flags straight from the occupancy count
  assign empty = (s.cnt == 2'h0);
  assign full = (s.cnt == 2'h2);
  assign head = s.ent[s.rd];

  // Circular pointers; a push into a full FIFO is refused
  always_comb
  begin
    n = s;
    if (push && !full)
    begin
      n.ent[s.wr] = din;
      n.wr = ~s.wr;
    end
    if (pop && !empty)
      n.rd = ~s.rd;
    n.cnt = s.cnt + {1'b0, push && !full} - {1'b0, pop && !empty};
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  property p_pop_step;
    @(posedge mclk) disable iff (!rst_n)
      (pop && !empty && !push) |=> (s.cnt == $past(s.cnt) - 2'h1);
  endproperty
  a_pop_step: assert property (p_pop_step)
    else $error("pop did not free one entry");

  property p_keep;
    @(posedge mclk) disable iff (!rst_n)
      (push && empty && !pop) |=> (head == $past(din));
  endproperty
  a_keep: assert property (p_keep)
    else $error("pushed entry not at head");
endmodule

// >>> testbench/usc_peer.sv
// Remote serial device model sitting on the data lines
`timescale 1ns/1ps
module usc_peer (
  input wire logic mclk,
  input wire logic txd_o,
  output logic rxd_i,
  output logic xck_i
);
  int bit_cyc = 16; // Clocks per bit, set by the bench
  int nbits = 8; // Data bits per character
  int frames = 0; // Characters taken off the line
  logic pen = 1'b0; // Parity bit present
  logic stop2 = 1'b0; // Two stop bits sent
  logic sync = 1'b0; // Clock pin pulsed per bit, slave test
  logic [8:0] got; // Last character seen
  logic par_got; // Its parity bit
  logic stop_got; // Its first stop bit
  initial rxd_i = 1'b1; // Idle line rests high
  initial xck_i = 1'b0; // Clock pin idles low, no edge at start
  // One bit time; in sync mode one clock pulse, well under clk/4
  task automatic hold_bit();
    if (sync)
    begin
      xck_i <= 1'b1; // Change edge with polarity clear
      repeat (8) @(posedge mclk);
      xck_i <= 1'b0; // Sample edge
      repeat (8) @(posedge mclk);
    end
    else
      repeat (bit_cyc) @(posedge mclk);
  endtask
  // One frame out: start, data LSB first, parity, stops
  task automatic send(input logic [8:0] d, input logic par,
    input logic bad);
    rxd_i <= 1'b0;
    hold_bit();
    for (int i = 0; i < nbits; i++)
    begin
      rxd_i <= d[i];
      hold_bit();
    end
    // Parity only when enabled
    if (pen)
    begin
      rxd_i <= par;
      hold_bit();
    end
    rxd_i <= ~bad; // A low stop provokes a frame error
    hold_bit();
    // Second stop is always high; else one idle cycle between frames
    rxd_i <= 1'b1;
    if (stop2)
      hold_bit();
    else
      @(posedge mclk);
  endtask
  // Takes each frame off the transmit line at mid-bit
  initial
  begin
    forever
    begin
      @(negedge txd_o);
      got = 9'h0;
      repeat (bit_cyc / 2) @(posedge mclk);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (bit_cyc) @(posedge mclk);
        got[i] = txd_o;
      end
      if (pen)
      begin
        repeat (bit_cyc) @(posedge mclk);
        par_got = txd_o;
      end
      repeat (bit_cyc) @(posedge mclk);
      stop_got = txd_o;
      frames++;
    end
  end
endmodule

// >>> testbench/tb_usart_clocking_and_framing.sv
// Self-checking bench of the serial unit over APB and the data lines
`timescale 1ns/1ps
`include "usc_consts.svh"
module tb_usart_clocking_and_framing;
  logic mclk = 1'b0; // 100 MHz system clock
  logic arst_n = 1'b0; // Reset, active low
  usc_pkg::usc_apb_req_t apb = '0; // Bus request
  logic [31:0] prdata;
  logic pready, pslverr, txd_o, xck_o, xck_oe, rxd_i, xck_i;
  logic [31:0] q; // Last read word
  logic err; // Last error response
  logic [31:0] seed = 32'h34E312AF; // Random state, fixed start
  int fails = 0;
  int checks = 0;
  always #5 mclk = ~mclk;
  // Peer drives the data line and, for slave tests, the clock pin
  usc_top dut (.mclk(mclk), .arst_n(arst_n), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_i(rxd_i), .txd_o(txd_o), .xck_i(xck_i), .xck_o(xck_o),
    .xck_oe(xck_oe));
  usc_peer peer (.mclk(mclk), .txd_o(txd_o), .rxd_i(rxd_i),
    .xck_i(xck_i));
  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Parity over the low n bits, inverted when odd
  function automatic logic par(input logic [8:0] d, input int n,
    input logic odd);
    return (^(d & (9'h1FF >> (9 - n)))) ^ odd;
  endfunction
  task automatic results();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  // One APB transfer; held until pready is seen high
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge mclk);
    apb.penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        fails++;
        results();
      end
      @(posedge mclk);
    end
    q = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Bounded wait for the peer to finish taking a frame
  task automatic wait_tx(input int f0);
    int n;
    n = 0;
    while (peer.frames == f0)
    begin
      n++;
      if (n > 40000)
      begin
        fails++;
        results();
      end
      @(posedge mclk);
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (95000) @(posedge mclk);
    fails++;
    results();
  end
  // Main sequence
  initial
  begin
    logic [8:0] d, msk;
    logic [31:0] c;
    logic [2:0] sz;
    logic [1:0] pm, dv;
    logic st, u2x, x0;
    int nb, f0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset value, divisor width, unmapped place
    rd(`USC_OFS_CTRL);
    chk("ctrl reset", q, 32'h00000C00);
    rd(12'h0FC);
    chk("unmapped", {q[30:0], err}, 32'h1);
    wr(`USC_OFS_BHI, 32'hFFFFFFFF);
    rd(`USC_OFS_BHI);
    chk("divisor high", q, 32'hF);
    // Sizes five, eight and nine, parity modes, stop counts, both ways
    for (int k = 0; k < 18; k++)
    begin
      sz = (k % 3 == 0) ? 3'h0 : (k % 3 == 1) ? 3'h3 : 3'h7;
      nb = (sz == 3'h7) ? 9 : int'(sz) + 5;
      pm = ((k / 3) % 3 == 0) ? 2'h0 : 2'((k / 3) % 3 + 1);
      st = (k >= 9);
      c = rnd();
      dv = c[1:0];
      u2x = c[2];
      d = 9'(rnd());
      msk = 9'h1FF >> (9 - nb);
      wr(`USC_OFS_BHI, 32'h0);
      wr(`USC_OFS_BLO, {30'h0, dv});
      wr(`USC_OFS_CTRL, {19'h0, sz, pm, st, 3'h0, d[8], u2x, 2'h3});
      peer.bit_cyc = (u2x ? 8 : 16) * (int'(dv) + 1);
      peer.nbits = nb;
      peer.pen = pm[1];
      peer.stop2 = st;
      wr(`USC_OFS_STAT, 32'h4);
      f0 = peer.frames;
      wr(`USC_OFS_DATA, {23'h0, d});
      wait_tx(f0);
      chk("tx char", peer.got, d & msk);
      if (pm[1])
        chk("tx parity", peer.par_got, par(d, nb, pm[0]));
      chk("tx stop", peer.stop_got, 32'h1);
      repeat (3 * peer.bit_cyc) @(posedge mclk);
      rd(`USC_OFS_STAT);
      chk("tx complete", q[`USC_S_TXC], 32'h1);
      peer.send(d & msk, par(d, nb, pm[0]), 1'b0);
      rd(`USC_OFS_STAT);
      chk("rx status", q & 32'h79,
        {25'h0, 1'b0, d[8] & (nb == 9), 4'h0, 1'b1});
      rd(`USC_OFS_DATA);
      chk("rx char", q, {23'h0, d & msk});
    end
    // Three characters unread: FIFO plus shift register
    wr(`USC_OFS_BLO, 32'h0);
    wr(`USC_OFS_CTRL, 32'h00000C03);
    peer.bit_cyc = 16;
    peer.nbits = 8;
    peer.pen = 1'b0;
    peer.stop2 = 1'b0;
    for (int i = 0; i < 3; i++)
      peer.send(9'(8'hA0 + i), 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      rd(`USC_OFS_DATA);
      chk("fifo char", q, 32'hA0 + i);
    end
    // Fourth start drops the held third; overrun rides with the fourth
    for (int i = 0; i < 4; i++)
      peer.send(9'(8'hB0 + i), 1'b0, 1'b0);
    rd(`USC_OFS_DATA);
    chk("ovr first", q, 32'hB0);
    rd(`USC_OFS_DATA);
    chk("ovr second", q, 32'hB1);
    rd(`USC_OFS_STAT);
    chk("overrun flag", q[`USC_S_DOR], 32'h1);
    rd(`USC_OFS_DATA);
    chk("overrun char", q, 32'hB3);
    // Low first stop bit gives a frame error
    peer.send(9'h5A, 1'b0, 1'b1);
    repeat (48) @(posedge mclk);
    rd(`USC_OFS_STAT);
    chk("frame error", q & 32'h18, 32'h8);
    rd(`USC_OFS_DATA);
    chk("fe char", q, 32'h5A);
    // Sync master: clock pin driven, one tick per half period
    wr(`USC_OFS_BLO, 32'h3);
    wr(`USC_OFS_CTRL, 32'h00000C34);
    repeat (20) @(posedge mclk);
    chk("clock pin driven", xck_oe, 32'h1);
    for (int j = 0; j < 2; j++)
    begin
      c = 0;
      x0 = xck_o;
      while (xck_o === x0 && c < 50)
      begin
        @(negedge mclk);
        c++;
      end
    end
    chk("master half period", c, 32'h4);
    @(posedge mclk);
    wr(`USC_OFS_CTRL, 32'h00000C20);
    repeat (4) @(posedge mclk);
    chk("clock pin released", xck_oe, 32'h0);
    // Sync slave receive: peer pulses the clock pin once per bit
    wr(`USC_OFS_CTRL, 32'h00000C11);
    peer.sync = 1'b1;
    peer.send(9'h03C, 1'b0, 1'b0);
    peer.sync = 1'b0;
    rd(`USC_OFS_DATA);
    chk("sync slave char", q, 32'h3C);
    results();
  end
endmodule
